// [sim/rcs_ctrl_tb_top.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module rcs_ctrl_tb_top
    import rcs_pkg::*;
;
    logic clk_sys, resetn, reg_wr, reg_rd, core_rst_n, tap_rst_n, bor_irq, wdt_irq, main_crystal_osc_enable;
    logic ext_rst_pin_n, bod_detect, sysreset_req, deep_sleep;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv, exp_d;
    logic [95:0] periph_rst_n;
    logic [REGULATOR_ADJUST_FIELD_W-1:0] regulator_adjust_field;
    rcs_clk_src_type clk_src;
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    logic rd_d = 1'b0; // Read taken on the last edge
    int mismatches = 0, samples_checked = 0, seed = 5, n;
    logic [31:0] rcc_v [5] = '{32'h810, 32'h800, 32'h820, 32'h830, 32'h000};
    rcs_clk_src_type src_v [5] = '{SRC_INTERNAL_OSC_12M, SRC_MAIN_CRYSTAL_OSC, SRC_INTERNAL_OSC_12M_DIV4, SRC_OSC30K, SRC_PLL};

    rcs_ctrl #(.NUM_SRCR(3), .WDT_W(32)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .ext_rst_pin_n(ext_rst_pin_n), .bod_detect(bod_detect), .sysreset_req(sysreset_req),
        .deep_sleep(deep_sleep), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_rst_n(core_rst_n), .periph_rst_n(periph_rst_n),
        .tap_rst_n(tap_rst_n), .bor_irq(bor_irq), .wdt_irq(wdt_irq), .clk_src(clk_src),
        .regulator_adjust_field(regulator_adjust_field), .main_crystal_osc_enable(main_crystal_osc_enable));
    rcs_far_model i_far (.clk_sys(clk_sys), .ext_rst_pin_n(ext_rst_pin_n), .bod_detect(bod_detect),
        .sysreset_req(sysreset_req), .deep_sleep(deep_sleep));

    // Clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // One-cycle register write
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // One-cycle register read, expectation noted for the monitor
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    // Waits a bounded time for the system reset to lift
    task wait_rst();
        n = 0;
        while (core_rst_n !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("core_rst_n", 1'b1, core_rst_n)
    endtask
    // Prints the counts and the verdict, then ends the run
    task stop_test();
        $display("compares %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Read data monitor: data stands in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_d) begin
            exp_d = exp_q.pop_front();
            `CHK("reg_rdata", exp_d, reg_rdata)
        end
        rd_d <= reg_rd;
    end
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
    // Main sequence
    initial begin
        resetn = 1'b0;
        reg_addr = 8'($random(seed));
        reg_wdata = $random(seed);
        reg_wr = 1'($random(seed));
        reg_rd = 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        reg_wr <= 1'b0;
        repeat (4) @(posedge clk_sys);
        `CHK("clk_src", SRC_INTERNAL_OSC_12M, clk_src)
        rd(ADDR_RESET_CAUSE_REGISTER, 32'h2);
        rd(8'hfc, 32'h0);
        // Brown-out with reset disabled only interrupts
        i_far.set_bod(1'b1);
        repeat (6) @(posedge clk_sys);
        `CHK("bor_irq", 1'b1, bor_irq)
        `CHK("core_rst_n", 1'b1, core_rst_n)
        i_far.set_bod(1'b0);
        repeat (4) @(posedge clk_sys);
        wr(ADDR_POR_BROWNOUT_CONTROL_REGISTER, 32'h2);
        i_far.set_bod(1'b1);
        repeat (30) @(posedge clk_sys);
        `CHK("core_rst_n", 1'b0, core_rst_n)
        `CHK("tap_rst_n", 1'b1, tap_rst_n)
        i_far.set_bod(1'b0);
        repeat (18) @(posedge clk_sys);
        `CHK("core_rst_n", 1'b0, core_rst_n)
        wait_rst();
        rd(ADDR_RESET_CAUSE_REGISTER, 32'h6);
        rd(ADDR_POR_BROWNOUT_CONTROL_REGISTER, 32'h0);
        // Core request resets the core and every peripheral, not the test port
        i_far.req_reset();
        repeat (2) @(posedge clk_sys);
        `CHK("periph_rst_n", {96{1'b0}}, periph_rst_n)
        wait_rst();
        rd(ADDR_RESET_CAUSE_REGISTER, 32'he);
        // Soft resets, random bit patterns in each register
        for (int r = 0; r < 3; r++) begin
            rv = $random(seed);
            wr(8'(ADDR_SRCR0 + ADDR_STEP * r), rv);
            repeat (3) @(posedge clk_sys);
            `CHK("periph_rst_n", ~rv, periph_rst_n[32*r +: 32])
            rd(8'(ADDR_SRCR0 + ADDR_STEP * r), rv);
            wr(8'(ADDR_SRCR0 + ADDR_STEP * r), 32'h0);
            repeat (3) @(posedge clk_sys);
            `CHK("periph_rst_n", {96{1'b1}}, periph_rst_n)
        end
        rv = $random(seed);
        wr(ADDR_LDO, rv);
        repeat (2) @(posedge clk_sys);
        `CHK("regulator", rv[REGULATOR_ADJUST_FIELD_W-1:0], regulator_adjust_field)
        // Main oscillator powered for each of the five sources chosen
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_RCC, rcc_v[i]);
            repeat (3) @(posedge clk_sys);
            `CHK("main_crystal_osc_enable", 1'b1, main_crystal_osc_enable)
            `CHK("clk_src", src_v[i], clk_src)
        end
        wr(ADDR_RCC, 32'h810);
        wr(ADDR_RCC2, 32'h8000_0070);
        repeat (3) @(posedge clk_sys);
        `CHK("clk_src", SRC_RTC, clk_src)
        wr(ADDR_RCC2, 32'h1);
        i_far.set_sleep(1'b1);
        repeat (3) @(posedge clk_sys);
        `CHK("clk_src", SRC_OSC30K, clk_src)
        `CHK("main_crystal_osc_enable", 1'b0, main_crystal_osc_enable)
        i_far.set_sleep(1'b0);
        // Watchdog: interrupt first, reset on the second time-out
        wr(ADDR_WDT_LOAD, 32'h20);
        wr(ADDR_WDT_CTL, 32'h3);
        n = 0;
        while (wdt_irq !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (20) @(posedge clk_sys);
        `CHK("wdt_irq", 1'b1, wdt_irq)
        `CHK("core_rst_n", 1'b1, core_rst_n)
        // Serviced flag: the next time-out raises it again without a reset
        wr(ADDR_WDT_ICR, 32'h0);
        rd(ADDR_WDT_ICR, 32'h0);
        repeat (20) @(posedge clk_sys);
        `CHK("wdt_irq", 1'b1, wdt_irq)
        `CHK("core_rst_n", 1'b1, core_rst_n)
        repeat (30) @(posedge clk_sys);
        `CHK("core_rst_n", 1'b0, core_rst_n)
        wait_rst();
        rd(ADDR_RESET_CAUSE_REGISTER, 32'h1e);
        // Pin reset passes the synchroniser, spares the test port
        i_far.set_pin(1'b0);
        @(posedge clk_sys);
        `CHK("core_rst_n", 1'b1, core_rst_n)
        repeat (10) @(posedge clk_sys);
        `CHK("core_rst_n", 1'b0, core_rst_n)
        `CHK("tap_rst_n", 1'b1, tap_rst_n)
        i_far.set_pin(1'b1);
        wait_rst();
        rd(ADDR_RESET_CAUSE_REGISTER, 32'h1);
        repeat (3) @(posedge clk_sys);
        stop_test();
    end
endmodule // rcs_ctrl_tb_top

// [sim/rcs_far_model.sv]
`timescale 1ns/1ns
// Stands in for the reset pin, supply supervisor and core beside the block
module rcs_far_model (
    input wire logic clk_sys, // System clock
    output logic ext_rst_pin_n, // Reset pin level
    output logic bod_detect, // Supply-low flag
    output logic sysreset_req, // Core reset request pulse
    output logic deep_sleep // Core deep-sleep level
);
    int seed = 5; // Seed for the random start levels
    // Pin released, no request; detector and sleep start random, harmless while their enables are clear
    initial begin
        ext_rst_pin_n = 1'b1;
        bod_detect = 1'($random(seed));
        sysreset_req = 1'b0;
        deep_sleep = 1'($random(seed));
    end
    // Drives the reset pin level
    task set_pin(input logic v);
        @(posedge clk_sys);
        ext_rst_pin_n <= v;
    endtask
    // Drives the supply-low flag
    task set_bod(input logic v);
        @(posedge clk_sys);
        bod_detect <= v;
    endtask
    // Drives the deep-sleep level
    task set_sleep(input logic v);
        @(posedge clk_sys);
        deep_sleep <= v;
    endtask
    // One-cycle system reset request from the core
    task req_reset();
        @(posedge clk_sys);
        sysreset_req <= 1'b1;
        @(posedge clk_sys);
        sysreset_req <= 1'b0;
    endtask
endmodule // rcs_far_model

// [src/rcs_ctrl.sv]
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module rcs_ctrl
    import rcs_pkg::*;
#(
    parameter int NUM_SRCR = 3,
    parameter int WDT_W = 32
) (
    input wire logic clk_sys, // System clock
    input wire logic resetn, // Power-on reset, active low
    input wire logic ext_rst_pin_n, // External reset pin, asynchronous
    input wire logic bod_detect, // Brown-out detector, asynchronous
    input wire logic sysreset_req, // Core system reset request pulse
    input wire logic deep_sleep, // Core is in deep-sleep
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    output logic core_rst_n, // Core and system reset, active low
    output logic [NUM_SRCR*32-1:0] periph_rst_n, // Peripheral resets, active low
    output logic tap_rst_n, // Test port reset, active low
    output logic bor_irq, // Brown-out interrupt level
    output logic wdt_irq, // Watchdog first time-out interrupt
    output logic [REGULATOR_ADJUST_FIELD_W-1:0] regulator_adjust_field, // Regulator setting
    output rcs_clk_src_type clk_src, // Selected system clock source
    output logic main_crystal_osc_enable // Main oscillator power
);

    // Address match for one soft reset register
    function automatic logic srcr_hit(input logic [7:0] addr, input int idx);
        return addr == ADDR_SRCR0 + 8'(idx * ADDR_STEP);
    endfunction

    // Clock source decode from configuration
    function automatic rcs_clk_src_type src_decode(input logic [31:0] run_clock_config_register, input logic [31:0] rcc2,
                                                   input logic dslp);
        logic [1:0] osc;
        osc = run_clock_config_register[RCC_OSC_SOURCE_SELECT_LSB +: 2];
        if (dslp && rcc2[RCC2_DSLP30K_BIT]) begin
            return SRC_OSC30K;
        end else if (run_clock_config_register[RCC_BYPASS_BIT] && rcc2[RCC2_USE_BIT] && rcc2[RCC2_OSC_SOURCE_SELECT_EXTENDED_LSB +: 3] == OSC2_RTC) begin
            return SRC_RTC;
        end else if (!run_clock_config_register[RCC_BYPASS_BIT] && osc == OSC_MAIN) begin
            return SRC_PLL;
        end else begin
            case (osc)
                OSC_MAIN: return SRC_MAIN_CRYSTAL_OSC;
                OSC_INT: return SRC_INTERNAL_OSC_12M;
                OSC_INT_DIV4: return SRC_INTERNAL_OSC_12M_DIV4;
                default: return SRC_OSC30K;
            endcase
        end
    endfunction

    logic rst_meta_n; // Reset release first stage
    logic rst_sync_n; // Reset used by the design
    logic [1:0] sync_q; // Synchronised pin and detector
    logic ext_hold; // External pin held low
    logic bod_s; // Brown-out detected
    logic bor_rst_en; // Brown-out reset enable bit
    logic bor_trig; // Brown-out converted to reset
    logic hold_bor; // Active reset caused by brown-out
    rcs_state_type state; // Reset sequencer state
    rcs_state_type next_state; // Its next value
    logic [RST_CNT_W-1:0] hold_cnt; // Stretch counter
    logic sys_clr; // System reset in progress
    logic enter_rst; // Leaving run this cycle
    logic [RESET_CAUSE_REGISTER_W-1:0] reset_cause_register; // Reset cause bits
    logic [RESET_CAUSE_REGISTER_W-1:0] next_reset_cause_register; // Its next value
    logic [31:0] srcr [NUM_SRCR]; // Peripheral soft reset registers
    logic [WDT_W-1:0] wdt_load; // Watchdog reload value
    logic [WDT_W-1:0] wdt_cnt; // Watchdog down-counter
    logic wdt_inten; // Watchdog counting and interrupt enable
    logic wdt_resen; // Watchdog reset enable
    logic wdt_timeout; // Counter at zero while enabled
    logic wdt_rst_req; // Second time-out reset pulse
    logic [31:0] run_clock_config_register; // Run clock configuration
    logic [31:0] rcc2; // Extended run clock configuration
    logic [31:0] next_rdata; // Read data before the flop
    logic wr_en; // Write accepted

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Pin and detector synchroniser
    rcs_sync #(
        .WIDTH(2),
        .RST_VAL(2'h2)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_sync_n),
        .d({ext_rst_pin_n, bod_detect}),
        .q(sync_q)
    );

    assign ext_hold = !sync_q[1];
    assign bod_s = sync_q[0];
    assign bor_trig = bod_s && bor_rst_en;
    assign sys_clr = state != ST_RUN;
    assign enter_rst = state == ST_RUN && next_state != ST_RUN;
    assign wr_en = reg_wr && !sys_clr;
    assign wdt_timeout = wdt_inten && wdt_cnt == '0;

    // Reset sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (ext_hold || bor_trig || sysreset_req || wdt_rst_req) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!ext_hold && !(hold_bor && bod_s)) begin
                    next_state = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (ext_hold) begin
                    next_state = ST_ACTIVE;
                end else if (hold_cnt == RST_CNT_W'(RST_HOLD_CYC - 1)) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // Sequencer state and stretch counter
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_RUN;
            hold_cnt <= '0;
        end else begin
            state <= next_state;
            hold_cnt <= (state == ST_STRETCH) ? hold_cnt + 1'b1 : '0;
        end
    end

    // Remember a brown-out entry across the enable clear
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_bor <= 1'b0;
        end else if (enter_rst) begin
            hold_bor <= bor_trig;
        end else if (next_state == ST_RUN) begin
            hold_bor <= 1'b0;
        end
    end

    // Reset outputs; test port only follows power-on
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            core_rst_n <= 1'b0;
            periph_rst_n <= '0;
            tap_rst_n <= 1'b0;
        end else begin
            core_rst_n <= next_state == ST_RUN;
            for (int i = 0; i < NUM_SRCR; i++) begin
                periph_rst_n[i*32 +: 32] <= ~srcr[i] & {32{next_state == ST_RUN}};
            end
            tap_rst_n <= 1'b1;
        end
    end

    // Reset cause next value; hardware set wins over write
    always_comb begin
        next_reset_cause_register = (reg_wr && reg_addr == ADDR_RESET_CAUSE_REGISTER) ? reg_wdata[RESET_CAUSE_REGISTER_W-1:0] : reset_cause_register;
        if (enter_rst) begin
            if (ext_hold) begin
                next_reset_cause_register = RESET_CAUSE_REGISTER_EXT_VAL;
            end else begin
                next_reset_cause_register[RESET_CAUSE_REGISTER_BOR_BIT] = next_reset_cause_register[RESET_CAUSE_REGISTER_BOR_BIT] | bor_trig;
                next_reset_cause_register[RESET_CAUSE_REGISTER_SW_BIT] = next_reset_cause_register[RESET_CAUSE_REGISTER_SW_BIT] | sysreset_req;
                next_reset_cause_register[RESET_CAUSE_REGISTER_WDT_BIT] = next_reset_cause_register[RESET_CAUSE_REGISTER_WDT_BIT] | wdt_rst_req;
            end
        end
    end

    // Reset cause register, sticky across system resets other than the pin reset
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reset_cause_register <= RESET_CAUSE_REGISTER_POR_VAL;
        end else begin
            reset_cause_register <= next_reset_cause_register;
        end
    end

    // Brown-out control and interrupt
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bor_rst_en <= 1'b0;
            bor_irq <= 1'b0;
        end else begin
            if (sys_clr) begin
                bor_rst_en <= 1'b0;
            end else if (wr_en && reg_addr == ADDR_POR_BROWNOUT_CONTROL_REGISTER) begin
                bor_rst_en <= reg_wdata[PBOR_RSTEN_BIT];
            end
            bor_irq <= bod_s && !bor_rst_en;
        end
    end

    // Soft reset registers, one per group of peripherals
    generate
        for (genvar g = 0; g < NUM_SRCR; g++) begin : g_srcr
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    srcr[g] <= '0;
                end else if (sys_clr) begin
                    srcr[g] <= '0;
                end else if (wr_en && srcr_hit(reg_addr, g)) begin
                    srcr[g] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Watchdog configuration
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_load <= WDT_W'(WDT_LOAD_RST);
            wdt_inten <= 1'b0;
            wdt_resen <= 1'b0;
        end else if (sys_clr) begin
            wdt_load <= WDT_W'(WDT_LOAD_RST);
            wdt_inten <= 1'b0;
            wdt_resen <= 1'b0;
        end else if (wr_en && reg_addr == ADDR_WDT_LOAD) begin
            wdt_load <= reg_wdata[WDT_W-1:0];
        end else if (wr_en && reg_addr == ADDR_WDT_CTL) begin
            wdt_inten <= reg_wdata[WDT_INTEN_BIT];
            wdt_resen <= reg_wdata[WDT_RESEN_BIT];
        end
    end

    // Watchdog down-counter
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_cnt <= WDT_W'(WDT_LOAD_RST);
        end else if (sys_clr) begin
            wdt_cnt <= WDT_W'(WDT_LOAD_RST);
        end else if (wr_en && reg_addr == ADDR_WDT_LOAD) begin
            wdt_cnt <= reg_wdata[WDT_W-1:0];
        end else if (wdt_timeout) begin
            wdt_cnt <= wdt_load;
        end else if (wdt_inten) begin
            wdt_cnt <= wdt_cnt - 1'b1;
        end
    end

    // Watchdog interrupt flag and reset request
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_irq <= 1'b0;
            wdt_rst_req <= 1'b0;
        end else begin
            if (sys_clr) begin
                wdt_irq <= 1'b0;
            end else if (wdt_timeout) begin
                wdt_irq <= 1'b1;
            end else if (wr_en && reg_addr == ADDR_WDT_ICR) begin
                wdt_irq <= 1'b0;
            end
            wdt_rst_req <= wdt_timeout && wdt_irq && wdt_resen && !sys_clr;
        end
    end

    // Regulator and clock configuration
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            regulator_adjust_field <= REGULATOR_ADJUST_FIELD_RST;
            run_clock_config_register <= RCC_RST;
            rcc2 <= RCC2_RST;
        end else if (sys_clr) begin
            regulator_adjust_field <= REGULATOR_ADJUST_FIELD_RST;
            run_clock_config_register <= RCC_RST;
            rcc2 <= RCC2_RST;
        end else if (wr_en && reg_addr == ADDR_LDO) begin
            regulator_adjust_field <= reg_wdata[REGULATOR_ADJUST_FIELD_W-1:0];
        end else if (wr_en && reg_addr == ADDR_RCC) begin
            run_clock_config_register <= reg_wdata;
        end else if (wr_en && reg_addr == ADDR_RCC2) begin
            rcc2 <= reg_wdata;
        end
    end

    // Clock source selection and main oscillator power
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clk_src <= SRC_INTERNAL_OSC_12M;
            main_crystal_osc_enable <= 1'b0;
        end else begin
            clk_src <= src_decode(run_clock_config_register, rcc2, deep_sleep);
            main_crystal_osc_enable <= !run_clock_config_register[RCC_MAIN_CRYSTAL_OSC_DIS_BIT] && !(deep_sleep && rcc2[RCC2_DSLP30K_BIT]);
        end
    end

    // Read decode
    always_comb begin
        next_rdata = 32'h0;
        if (reg_addr == ADDR_POR_BROWNOUT_CONTROL_REGISTER) begin
            next_rdata[PBOR_RSTEN_BIT] = bor_rst_en;
        end else if (reg_addr == ADDR_RESET_CAUSE_REGISTER) begin
            next_rdata = 32'(reset_cause_register);
        end else if (reg_addr == ADDR_WDT_LOAD) begin
            next_rdata = 32'(wdt_load);
        end else if (reg_addr == ADDR_WDT_CTL) begin
            next_rdata[WDT_INTEN_BIT] = wdt_inten;
            next_rdata[WDT_RESEN_BIT] = wdt_resen;
        end else if (reg_addr == ADDR_WDT_ICR) begin
            next_rdata[0] = wdt_irq;
        end else if (reg_addr == ADDR_WDT_VALUE) begin
            next_rdata = 32'(wdt_cnt);
        end else if (reg_addr == ADDR_LDO) begin
            next_rdata = 32'(regulator_adjust_field);
        end else if (reg_addr == ADDR_RCC) begin
            next_rdata = run_clock_config_register;
        end else if (reg_addr == ADDR_RCC2) begin
            next_rdata = rcc2;
        end else begin
            for (int i = 0; i < NUM_SRCR; i++) begin
                if (srcr_hit(reg_addr, i)) begin
                    next_rdata = srcr[i];
                end
            end
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end

    // Checks
    localparam int HOLD_MAX = 24;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    a_bor_en_cleared: assert property (!core_rst_n |=> !bor_rst_en)
        else $error("brown-out enable survived reset");
    a_bor_irq_raise: assert property (bod_s && !bor_rst_en |=> bor_irq)
        else $error("brown-out interrupt missing");
    a_bor_to_reset: assert property (state == ST_RUN && bor_trig |=> state == ST_ACTIVE ##1 !core_rst_n)
        else $error("brown-out reset not taken");
    a_bor_held_low: assert property (state == ST_ACTIVE && hold_bor && bod_s |=> !core_rst_n && state == ST_ACTIVE)
        else $error("brown-out reset released early");
    a_bor_cause_set: assert property (state == ST_RUN && bor_trig && !ext_hold |=> reset_cause_register[RESET_CAUSE_REGISTER_BOR_BIT])
        else $error("brown-out cause not recorded");
    a_srcr_bit_reset: assert property (srcr[0][0] && state == ST_RUN |=> !periph_rst_n[0])
        else $error("soft reset bit ignored");
    a_sysreq_cycle: assert property (state == ST_RUN && sysreset_req && !ext_hold
                                     |=> !core_rst_n ##[1:HOLD_MAX] core_rst_n)
        else $error("system reset request not sequenced");
    a_wdt_first_reload: assert property (wdt_timeout && !wdt_irq && !sys_clr && !wr_en
                                         |=> wdt_irq && wdt_cnt == $past(wdt_load))
        else $error("watchdog first time-out wrong");
    a_wdt_second_reset: assert property (wdt_timeout && wdt_irq && wdt_resen && !sys_clr
                                         |=> wdt_rst_req ##1 !core_rst_n)
        else $error("watchdog second time-out no reset");
    a_clk_div4_sel: assert property (run_clock_config_register[RCC_BYPASS_BIT] && run_clock_config_register[RCC_OSC_SOURCE_SELECT_LSB +: 2] == OSC_INT_DIV4
                                     && !rcc2[RCC2_USE_BIT] && !(deep_sleep && rcc2[RCC2_DSLP30K_BIT])
                                     |=> clk_src == SRC_INTERNAL_OSC_12M_DIV4)
        else $error("quarter oscillator not selected");
    a_ext_cause_only: assert property (enter_rst && ext_hold |=> reset_cause_register == RESET_CAUSE_REGISTER_EXT_VAL)
        else $error("pin reset cause wrong");

    c_bor_reset: cover property (state == ST_RUN && bor_trig);
    c_wdt_reset: cover property (wdt_rst_req);
    c_sysreq_reset: cover property (state == ST_RUN && sysreset_req);
    c_pll_select: cover property (clk_src == SRC_PLL);

endmodule // rcs_ctrl

// [src/rcs_pkg.sv]
package rcs_pkg;

    // Clock and reset stretch timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_HOLD_NS = 1000;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_POR_BROWNOUT_CONTROL_REGISTER = 8'h00;
    localparam logic [7:0] ADDR_RESET_CAUSE_REGISTER = 8'h04;
    localparam logic [7:0] ADDR_SRCR0 = 8'h08;
    localparam logic [7:0] ADDR_WDT_LOAD = 8'h14;
    localparam logic [7:0] ADDR_WDT_CTL = 8'h18;
    localparam logic [7:0] ADDR_WDT_ICR = 8'h1c;
    localparam logic [7:0] ADDR_WDT_VALUE = 8'h20;
    localparam logic [7:0] ADDR_LDO = 8'h24;
    localparam logic [7:0] ADDR_RCC = 8'h28;
    localparam logic [7:0] ADDR_RCC2 = 8'h2c;
    localparam logic [7:0] ADDR_STEP = 8'h04;

    // Brown-out control fields
    localparam int PBOR_RSTEN_BIT = 1;

    // Reset cause fields
    localparam int RESET_CAUSE_REGISTER_W = 5;
    localparam int RESET_CAUSE_REGISTER_EXT_BIT = 0;
    localparam int RESET_CAUSE_REGISTER_POR_BIT = 1;
    localparam int RESET_CAUSE_REGISTER_BOR_BIT = 2;
    localparam int RESET_CAUSE_REGISTER_SW_BIT = 3;
    localparam int RESET_CAUSE_REGISTER_WDT_BIT = 4;
    localparam logic [RESET_CAUSE_REGISTER_W-1:0] RESET_CAUSE_REGISTER_POR_VAL = 5'h02;
    localparam logic [RESET_CAUSE_REGISTER_W-1:0] RESET_CAUSE_REGISTER_EXT_VAL = 5'h01;

    // Watchdog fields and reset values
    localparam int WDT_INTEN_BIT = 0;
    localparam int WDT_RESEN_BIT = 1;
    localparam logic [31:0] WDT_LOAD_RST = 32'hffff_ffff;

    // Regulator adjust field
    localparam int REGULATOR_ADJUST_FIELD_W = 6;
    localparam logic [REGULATOR_ADJUST_FIELD_W-1:0] REGULATOR_ADJUST_FIELD_RST = 6'h00;

    // Run clock configuration fields
    localparam int RCC_MAIN_CRYSTAL_OSC_DIS_BIT = 0;
    localparam int RCC_OSC_SOURCE_SELECT_LSB = 4;
    localparam int RCC_BYPASS_BIT = 11;
    localparam logic [31:0] RCC_RST = 32'h0000_0811;
    localparam int RCC2_DSLP30K_BIT = 0;
    localparam int RCC2_OSC_SOURCE_SELECT_EXTENDED_LSB = 4;
    localparam int RCC2_USE_BIT = 31;
    localparam logic [31:0] RCC2_RST = 32'h0000_0000;

    // Oscillator source codes
    localparam logic [1:0] OSC_MAIN = 2'h0;
    localparam logic [1:0] OSC_INT = 2'h1;
    localparam logic [1:0] OSC_INT_DIV4 = 2'h2;
    localparam logic [1:0] OSC_30K = 2'h3;
    localparam logic [2:0] OSC2_RTC = 3'h7;

    // Reset sequencer states, Gray on each step except ST_STRETCH to ST_RUN
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_STRETCH = 2'b11
    } rcs_state_type;

    // Selected system clock source
    typedef enum logic [2:0] {
        SRC_INTERNAL_OSC_12M = 3'h0,
        SRC_INTERNAL_OSC_12M_DIV4 = 3'h1,
        SRC_MAIN_CRYSTAL_OSC = 3'h2,
        SRC_OSC30K = 3'h3,
        SRC_RTC = 3'h4,
        SRC_PLL = 3'h5
    } rcs_clk_src_type;

endpackage

// [src/rcs_sync.sv]
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous levels
module rcs_sync
    import rcs_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic [WIDTH-1:0] d, // Asynchronous levels
    output logic [WIDTH-1:0] q // Synchronised levels
);

    logic [WIDTH-1:0] meta; // First stage, read only by q

    // Two flops in series
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // rcs_sync
